//--- core/i2mt_params.svh
`ifndef I2MT_PARAMS_SVH
`define I2MT_PARAMS_SVH
// register byte addresses
`define I2MT_A_CTRL1    8'h00
`define I2MT_A_CTRL2    8'h04
`define I2MT_A_STAT     8'h08
`define I2MT_A_BUF      8'h0C
`define I2MT_A_RELOAD   8'h10
`define I2MT_A_FLAGS    8'h14
// control_one fields
`define I2MT_C1_WRITE_COLLIDE_FLAG    7
`define I2MT_C1_PORTON  5
`define I2MT_MODE_MSTR  4'h8
// control_two fields
`define I2MT_C2_START   0
`define I2MT_C2_RSTART  1
`define I2MT_C2_ACKST   6
`define I2MT_C2_LOCK    5
// port_status_reg fields
`define I2MT_ST_FULL    0
`define I2MT_ST_SEEN    3
// flags register fields, generator width, bits per byte
`define I2MT_FL_EVENT   0
`define I2MT_FL_COLL    1
`define I2MT_RATE_W     7
`define I2MT_BITS       4'h8
`endif

//--- core/i2mt_pkg.sv
package i2mt_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S_WAIT, ST_S_LOW, ST_R_SCLLO, ST_R_SDAHI, ST_R_SCLHI,
    ST_R_BOTH, ST_R_LOW, ST_T_LOW, ST_T_HIGH
  } i2mt_state_t;
endpackage

//--- core/i2mt_master.sv
// Behaviour
// - start_request with both lines high loads rate generator and starts counting
// - lines still high at timeout: pull SDA low, set start_seen
// - reload; next timeout clears start_request, stops generator, SDA stays low
// - lines low at start or SCL low early: collision_flag, abort, idle
// - start done: hold SCL low, clear start_request, set port_event_flag
// - buffer write while busy is dropped and sets write_collide_flag
// - low five control_two bits locked during start or restart
// - restart from idle: SCL low, then load generator, release SDA
// - SDA high at timeout: release SCL; then both high, then SDA low
// - after SDA-low period clear restart_request, no reload, SDA low
// - start_seen at once; port_event_flag only after generator timeout
// - restart_request outside idle has no effect
// - restart collision: SDA low at SCL rise or SCL low early
// - buffer write sets buffer_full and starts the generator
// - bit on SDA after SCL falls; SCL low one period, high one period
// - eighth falling edge: clear buffer_full, release SDA
// - ninth falling edge: SDA into slave_reply_status
// - after ninth clock: port_event_flag, generator stopped, SCL low
// - generator counts down twice per instruction cycle from reload, then stops
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "i2mt_params.svh"
module i2mt_master #(
  parameter int RATE_W = `I2MT_RATE_W
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // i2c lines
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe
);
  if (RATE_W < 1 || RATE_W > 8) begin : g_rate_chk
    $error("RATE_W out of range");
  end

  // line synchronisers
  logic [1:0] sda_sync_r;
  logic [1:0] scl_sync_r;
  logic       sda_s;
  logic       scl_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_sync_r <= 2'h3;
      scl_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_sync_r <= {scl_sync_r[0], scl_in};
    end
  end
  assign sda_s = sda_sync_r[1];
  assign scl_s = scl_sync_r[1];

  // bus address phase capture
  logic        wr_pend_r;
  logic        rd_pend_r;
  logic [7:0]  addr_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      rd_pend_r <= hsel && htrans[1] && !hwrite;
      addr_r    <= haddr[7:0];
    end
  end

  // registers
  i2mt_pkg::i2mt_state_t state_r;
  logic              port_on_r;
  logic [3:0]        mode_r;
  logic              write_collide_flag_r;
  logic              start_req_r;
  logic              rstart_req_r;
  logic [2:0]        c2_misc_r;
  logic              ack_stat_r;
  logic              full_r;
  logic              seen_r;
  logic              event_r;
  logic              coll_r;
  logic [7:0]        buf_r;
  logic [RATE_W-1:0] reload_r;
  logic [RATE_W-1:0] brg_r;
  logic              brg_run_r;
  logic              phase_r;
  logic [7:0]        shift_r;
  logic [3:0]        bitn_r;

  logic busy;
  logic tick;
  logic idle_ok;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_buf;
  logic wr_rel;
  logic wr_flg;
  logic wr_stat;
  assign busy     = state_r != i2mt_pkg::ST_IDLE;
  assign idle_ok  = port_on_r && mode_r == `I2MT_MODE_MSTR;
  assign wr_ctrl1 = wr_pend_r && addr_r == `I2MT_A_CTRL1;
  assign wr_ctrl2 = wr_pend_r && addr_r == `I2MT_A_CTRL2;
  assign wr_buf   = wr_pend_r && addr_r == `I2MT_A_BUF;
  assign wr_rel   = wr_pend_r && addr_r == `I2MT_A_RELOAD;
  assign wr_flg   = wr_pend_r && addr_r == `I2MT_A_FLAGS;
  assign wr_stat  = wr_pend_r && addr_r == `I2MT_A_STAT;
  assign tick     = brg_run_r && brg_r == '0 && phase_r;

  // baud rate generator: one decrement per two hclk
  logic brg_load;
  logic brg_stop;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brg_r     <= '0;
      brg_run_r <= 1'b0;
      phase_r   <= 1'b0;
    end else if (brg_load) begin
      brg_r     <= reload_r;
      brg_run_r <= 1'b1;
      phase_r   <= 1'b0;
    end else if (brg_stop || tick) begin
      brg_run_r <= 1'b0;
      phase_r   <= 1'b0;
    end else if (brg_run_r) begin
      phase_r <= !phase_r;
      if (phase_r && brg_r != '0) begin
        brg_r <= brg_r - 1'b1;
      end
    end
  end

  // sequencer
  logic set_seen;
  logic set_event;
  logic set_coll;
  logic clr_start;
  logic clr_rstart;
  logic set_ack;
  logic sda_low_nxt;
  logic scl_low_nxt;
  logic sda_low_r;
  logic scl_low_r;
  logic go_start;
  logic go_rstart;
  logic buf_take;
  assign go_start  = state_r == i2mt_pkg::ST_IDLE && start_req_r && idle_ok;
  assign go_rstart = state_r == i2mt_pkg::ST_IDLE && rstart_req_r && idle_ok
                     && !start_req_r;
  assign buf_take  = wr_buf && !busy && !start_req_r && !rstart_req_r;

  i2mt_pkg::i2mt_state_t state_nxt;
  always_comb begin
    state_nxt   = state_r;
    brg_load    = 1'b0;
    brg_stop    = 1'b0;
    set_seen    = 1'b0;
    set_event   = 1'b0;
    set_coll    = 1'b0;
    clr_start   = 1'b0;
    clr_rstart  = 1'b0;
    set_ack     = 1'b0;
    sda_low_nxt = sda_low_r;
    scl_low_nxt = scl_low_r;
    unique case (state_r)
      i2mt_pkg::ST_IDLE: begin
        if (go_start) begin
          if (sda_s && scl_s) begin
            brg_load  = 1'b1;
            state_nxt = i2mt_pkg::ST_S_WAIT;
          end else if (!sda_s && !scl_s) begin
            set_coll  = 1'b1;
            clr_start = 1'b1;
          end
        end else if (go_rstart) begin
          scl_low_nxt = 1'b1;
          state_nxt   = i2mt_pkg::ST_R_SCLLO;
        end else if (buf_take) begin
          brg_load    = 1'b1;
          sda_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_T_LOW;
        end
      end
      i2mt_pkg::ST_S_WAIT: begin
        if (!scl_s) begin
          set_coll    = 1'b1;
          clr_start   = 1'b1;
          brg_stop    = 1'b1;
          sda_low_nxt = 1'b0;
          scl_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_IDLE;
        end else if (tick && sda_s) begin
          sda_low_nxt = 1'b1;
          set_seen    = 1'b1;
          brg_load    = 1'b1;
          state_nxt   = i2mt_pkg::ST_S_LOW;
        end else if (tick) begin
          set_coll  = 1'b1;
          clr_start = 1'b1;
          state_nxt = i2mt_pkg::ST_IDLE;
        end
      end
      i2mt_pkg::ST_S_LOW: begin
        if (tick) begin
          clr_start   = 1'b1;
          scl_low_nxt = 1'b1;
          set_event   = 1'b1;
          state_nxt   = i2mt_pkg::ST_IDLE;
        end
      end
      i2mt_pkg::ST_R_SCLLO: begin
        if (!scl_s) begin
          brg_load    = 1'b1;
          sda_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_R_SDAHI;
        end
      end
      i2mt_pkg::ST_R_SDAHI: begin
        if (tick && sda_s) begin
          scl_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_R_SCLHI;
        end else if (tick) begin
          set_coll    = 1'b1;
          clr_rstart  = 1'b1;
          scl_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_IDLE;
        end
      end
      i2mt_pkg::ST_R_SCLHI: begin
        if (scl_s && !sda_s) begin
          set_coll   = 1'b1;
          clr_rstart = 1'b1;
          state_nxt  = i2mt_pkg::ST_IDLE;
        end else if (scl_s) begin
          brg_load  = 1'b1;
          state_nxt = i2mt_pkg::ST_R_BOTH;
        end
      end
      i2mt_pkg::ST_R_BOTH: begin
        if (!scl_s || !sda_s) begin
          set_coll   = 1'b1;
          clr_rstart = 1'b1;
          brg_stop   = 1'b1;
          state_nxt  = i2mt_pkg::ST_IDLE;
        end else if (tick) begin
          sda_low_nxt = 1'b1;
          set_seen    = 1'b1;
          brg_load    = 1'b1;
          state_nxt   = i2mt_pkg::ST_R_LOW;
        end
      end
      i2mt_pkg::ST_R_LOW: begin
        if (tick) begin
          clr_rstart  = 1'b1;
          set_event   = 1'b1;
          scl_low_nxt = 1'b1; // park scl low so the next byte starts from a low clock
          state_nxt  = i2mt_pkg::ST_IDLE;
        end
      end
      i2mt_pkg::ST_T_LOW: begin
        if (tick) begin
          scl_low_nxt = 1'b0;
          state_nxt   = i2mt_pkg::ST_T_HIGH;
        end
      end
      i2mt_pkg::ST_T_HIGH: begin
        if (scl_s && !brg_run_r && !tick) begin
          brg_load = 1'b1; // clock stretching: count high time from seen high
        end else if (tick) begin
          scl_low_nxt = 1'b1;
          if (bitn_r == `I2MT_BITS) begin
            set_ack   = 1'b1;
            set_event = 1'b1;
            sda_low_nxt = 1'b0;
            state_nxt = i2mt_pkg::ST_IDLE;
          end else begin
            brg_load    = 1'b1;
            sda_low_nxt = bitn_r == 4'h7 ? 1'b0 : !shift_r[6];
            state_nxt   = i2mt_pkg::ST_T_LOW;
          end
        end
      end
      default: state_nxt = i2mt_pkg::ST_IDLE;
    endcase
  end

  // state, lines and shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r   <= i2mt_pkg::ST_IDLE;
      sda_low_r <= 1'b0;
      scl_low_r <= 1'b0;
      shift_r   <= 8'h00;
      bitn_r    <= 4'h0;
    end else begin
      state_r   <= state_nxt;
      scl_low_r <= scl_low_nxt;
      if (buf_take) begin
        sda_low_r <= !hwdata[7];
        shift_r   <= hwdata[7:0];
        bitn_r    <= 4'h0;
      end else begin
        sda_low_r <= sda_low_nxt;
      end
      if (state_r == i2mt_pkg::ST_T_HIGH && tick) begin
        shift_r <= {shift_r[6:0], 1'b0};
        bitn_r  <= bitn_r + 4'h1;
      end
    end
  end
  // open drain: enable only when pulling low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_oe  <= 1'b0;
      scl_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      sda_oe  <= sda_low_nxt || (buf_take && !hwdata[7]);
      scl_oe  <= scl_low_nxt;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // software registers
  logic blocked;
  assign blocked = busy || start_req_r || rstart_req_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_on_r    <= 1'b0;
      mode_r       <= 4'h0;
      write_collide_flag_r       <= 1'b0;
      start_req_r  <= 1'b0;
      rstart_req_r <= 1'b0;
      c2_misc_r    <= 3'h0;
      ack_stat_r   <= 1'b0;
      full_r       <= 1'b0;
      seen_r       <= 1'b0;
      event_r      <= 1'b0;
      coll_r       <= 1'b0;
      buf_r        <= 8'h00;
      reload_r     <= '0;
    end else begin
      if (wr_ctrl1) begin
        port_on_r <= hwdata[`I2MT_C1_PORTON];
        mode_r    <= hwdata[3:0];
        if (!hwdata[`I2MT_C1_WRITE_COLLIDE_FLAG]) write_collide_flag_r <= 1'b0;
      end
      if (wr_buf && blocked) write_collide_flag_r <= 1'b1;
      if (buf_take) begin
        buf_r  <= hwdata[7:0];
        full_r <= 1'b1;
      end else if (state_r == i2mt_pkg::ST_T_HIGH && tick && bitn_r == 4'h7) begin
        full_r <= 1'b0;
      end
      if (wr_ctrl2 && !(start_req_r || rstart_req_r)) begin
        start_req_r  <= hwdata[`I2MT_C2_START];
        rstart_req_r <= hwdata[`I2MT_C2_RSTART] && !busy;
        c2_misc_r    <= hwdata[4:2];
      end else begin
        if (clr_start) start_req_r <= 1'b0;
        if (clr_rstart) rstart_req_r <= 1'b0;
      end
      if (set_ack) ack_stat_r <= sda_s;
      if (set_seen) seen_r <= 1'b1;
      else if (wr_stat) seen_r <= hwdata[`I2MT_ST_SEEN];
      if (set_event) event_r <= 1'b1;
      else if (wr_flg && !hwdata[`I2MT_FL_EVENT]) event_r <= 1'b0;
      if (set_coll) coll_r <= 1'b1;
      else if (wr_flg && !hwdata[`I2MT_FL_COLL]) coll_r <= 1'b0;
      if (wr_rel) reload_r <= hwdata[RATE_W-1:0];
    end
  end

  // read data
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_r)
      `I2MT_A_CTRL1:  rd_mux = {24'h0, write_collide_flag_r, 1'b0, port_on_r, 1'b0, mode_r};
      `I2MT_A_CTRL2:  rd_mux = {24'h0, 1'b0, ack_stat_r, 1'b0, c2_misc_r,
                                rstart_req_r, start_req_r};
      `I2MT_A_STAT:   rd_mux = {24'h0, 4'h0, seen_r, 2'h0, full_r};
      `I2MT_A_BUF:    rd_mux = {24'h0, buf_r};
      `I2MT_A_RELOAD: rd_mux = 32'(reload_r);
      `I2MT_A_FLAGS:  rd_mux = {30'h0, coll_r, event_r};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= rd_pend_r ? rd_mux : 32'h0000_0000;
      hreadyout <= !(hsel && htrans[1] && hready && !hwrite);
      hresp     <= 1'b0;
    end
  end

  a_start_event: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == i2mt_pkg::ST_S_LOW && tick) |=> event_r && scl_oe && !start_req_r)
    else $error("start completion wrong");
  a_write_collide_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_buf && blocked) |=> write_collide_flag_r && $stable(buf_r))
    else $error("write collision not flagged");
  a_coll_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    set_coll |=> coll_r && state_r == i2mt_pkg::ST_IDLE)
    else $error("collision did not idle");
  a_full_set: assert property (@(posedge hclk) disable iff (!hresetn)
    buf_take |=> full_r && brg_run_r)
    else $error("buffer write did not start");
  a_seen_set: assert property (@(posedge hclk) disable iff (!hresetn)
    set_seen |=> seen_r ##1 sda_oe)
    else $error("start not seen");
  a_rstart_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (busy && wr_ctrl2 && !start_req_r && !rstart_req_r) |=> !rstart_req_r)
    else $error("restart accepted while busy");
  a_ack_sample: assert property (@(posedge hclk) disable iff (!hresetn)
    set_ack |=> ack_stat_r == $past(sda_s) && event_r)
    else $error("ack not sampled");
  a_brg_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && !brg_load |=> !brg_run_r)
    else $error("generator kept running");
endmodule
`default_nettype wire

//--- verification/i2mt_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2mt_slave_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // resolved bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // reply control and observation
  input  wire logic       nack,
  output logic            sda_pull,
  output logic [7:0]      got_byte,
  output logic [7:0]      start_cnt
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_n;

  // byte capture on scl rise, msb first; ack driven from eighth fall to ninth fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      bit_n     <= 4'h0;
      sda_pull  <= 1'b0;
      got_byte  <= 8'h00;
      start_cnt <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        start_cnt <= start_cnt + 8'h01;
        bit_n     <= 4'h0;
        sda_pull  <= 1'b0;
      end else if (scl && !scl_q) begin
        if (bit_n < 4'h8) begin
          got_byte <= {got_byte[6:0], sda};
        end
        bit_n <= bit_n + 4'h1;
      end else if (!scl && scl_q) begin
        if (bit_n == 4'h8) begin
          sda_pull <= !nack;
        end else if (bit_n == 4'h9) begin
          sda_pull <= 1'b0;
          bit_n    <= 4'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "i2mt_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        hready;
  logic        sda_out;
  logic        sda_oe;
  logic        scl_out;
  logic        scl_oe;
  logic        sda;
  logic        scl;
  logic        nack;
  logic        hold_sda;
  logic        hold_scl;
  logic        sda_pull;
  logic [7:0]  got_byte;
  logic [7:0]  start_cnt;
  logic [31:0] rd;
  int          error_cnt;
  int          num_checks;

  assign hready = hreadyout;
  // open-drain wires with pull-ups
  assign sda = !(sda_oe | sda_pull | hold_sda);
  assign scl = !(scl_oe | hold_scl);

  i2mt_master i2mt_master_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe)
  );

  i2mt_slave_model i2mt_slave_model_i (
    .clk(hclk), .rst_n(hresetn), .scl(scl), .sda(sda), .nack(nack),
    .sda_pull(sda_pull), .got_byte(got_byte), .start_cnt(start_cnt)
  );

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task rdr(input logic [7:0] a);
    ahb(1'b0, a, 32'h00000000);
  endtask

  // bounded poll of one register bit
  task wait_bit(input logic [7:0] a, input int b);
    for (int i = 0; i < 200; i++) begin
      rdr(a);
      if (rd[b] === 1'b1) break;
    end
  endtask

  task t_coll;
    @(posedge hclk);
    hold_sda <= 1'b1;
    hold_scl <= 1'b1;
    repeat (4) @(posedge hclk);
    wr(`I2MT_A_CTRL2, 32'h00000001);
    wait_bit(`I2MT_A_FLAGS, `I2MT_FL_COLL);
    `CHK(rd[`I2MT_FL_COLL], 1'b1)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_START], 1'b0)
    `CHK(sda_oe, 1'b0)
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    wr(`I2MT_A_FLAGS, 32'h00000000);
    $display("t_coll done");
  endtask

  task t_start;
    logic [7:0] sc;
    sc = start_cnt;
    wr(`I2MT_A_STAT, 32'h00000000);
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_SEEN], 1'b0)
    wr(`I2MT_A_CTRL2, 32'h00000001);
    wr(`I2MT_A_BUF, 32'h00000055);
    wr(`I2MT_A_CTRL2, 32'h00000000);
    rdr(`I2MT_A_CTRL1);
    `CHK(rd[`I2MT_C1_WRITE_COLLIDE_FLAG], 1'b1)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_START], 1'b1)
    wait_bit(`I2MT_A_FLAGS, `I2MT_FL_EVENT);
    `CHK(rd[`I2MT_FL_EVENT], 1'b1)
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_SEEN], 1'b1)
    `CHK(rd[`I2MT_ST_FULL], 1'b0)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_START], 1'b0)
    `CHK(scl_oe, 1'b1)
    `CHK(sda_oe, 1'b1)
    `CHK(start_cnt, sc + 8'h01)
    `CHK({sda_out, scl_out}, 2'b00)
    rdr(`I2MT_A_CTRL1);
    `CHK(rd[`I2MT_C1_WRITE_COLLIDE_FLAG], 1'b1)
    wr(`I2MT_A_CTRL1, 32'h00000028);
    rdr(`I2MT_A_CTRL1);
    `CHK(rd[`I2MT_C1_WRITE_COLLIDE_FLAG], 1'b0)
    wr(`I2MT_A_FLAGS, 32'h00000000);
    $display("t_start done");
  endtask

  task t_tx(input logic [7:0] b, input logic nk);
    nack <= nk;
    wr(`I2MT_A_BUF, {24'h000000, b});
    wr(`I2MT_A_BUF, {24'h000000, ~b});
    wr(`I2MT_A_CTRL2, 32'h00000002);
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_FULL], 1'b1)
    rdr(`I2MT_A_CTRL1);
    `CHK(rd[`I2MT_C1_WRITE_COLLIDE_FLAG], 1'b1)
    wait_bit(`I2MT_A_FLAGS, `I2MT_FL_EVENT);
    `CHK(rd[`I2MT_FL_EVENT], 1'b1)
    `CHK(got_byte, b)
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_FULL], 1'b0)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_ACKST], nk)
    `CHK(rd[`I2MT_C2_RSTART], 1'b0)
    `CHK(scl_oe, 1'b1)
    `CHK(sda_oe, 1'b0)
    wr(`I2MT_A_CTRL1, 32'h00000028);
    wr(`I2MT_A_FLAGS, 32'h00000000);
    $display("t_tx done");
  endtask

  task t_rcoll;
    @(posedge hclk);
    hold_sda <= 1'b1;
    wr(`I2MT_A_CTRL2, 32'h00000002);
    wait_bit(`I2MT_A_FLAGS, `I2MT_FL_COLL);
    `CHK(rd[`I2MT_FL_COLL], 1'b1)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_RSTART], 1'b0)
    `CHK(scl_oe, 1'b0)
    hold_sda <= 1'b0;
    wr(`I2MT_A_FLAGS, 32'h00000000);
    $display("t_rcoll done");
  endtask

  task t_restart;
    logic [7:0] sc;
    sc = start_cnt;
    wr(`I2MT_A_STAT, 32'h00000000);
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_SEEN], 1'b0)
    wr(`I2MT_A_CTRL2, 32'h00000002);
    wr(`I2MT_A_BUF, 32'h00000011);
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_RSTART], 1'b1)
    rdr(`I2MT_A_FLAGS);
    `CHK(rd[`I2MT_FL_EVENT], 1'b0)
    wait_bit(`I2MT_A_FLAGS, `I2MT_FL_EVENT);
    `CHK(rd[`I2MT_FL_EVENT], 1'b1)
    rdr(`I2MT_A_STAT);
    `CHK(rd[`I2MT_ST_SEEN], 1'b1)
    rdr(`I2MT_A_CTRL2);
    `CHK(rd[`I2MT_C2_RSTART], 1'b0)
    `CHK(sda_oe, 1'b1)
    `CHK(start_cnt, sc + 8'h01)
    rdr(`I2MT_A_CTRL1);
    `CHK(rd[`I2MT_C1_WRITE_COLLIDE_FLAG], 1'b1)
    wr(`I2MT_A_CTRL1, 32'h00000028);
    wr(`I2MT_A_FLAGS, 32'h00000000);
    $display("t_restart done");
  endtask

  task results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    hresetn    = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h00000000;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h00000000;
    nack       = 1'b0;
    hold_sda   = 1'b0;
    hold_scl   = 1'b0;
    error_cnt  = 0;
    num_checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // port on and master mode before any start
    wr(`I2MT_A_CTRL1, 32'h00000028);
    wr(`I2MT_A_RELOAD, 32'h00000003);
    t_coll;
    t_start;
    t_tx(8'hA6, 1'b0);
    t_tx(8'h5B, 1'b1);
    t_rcoll;
    t_restart;
    t_tx(8'h3C, 1'b0);
    results;
  end

  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    results;
  end
endmodule
`default_nettype wire
